// [mmd_defines.svh]
// Functional notes
// - Mode latched at reset picks the map and whether external access is allowed.
// - On-chip resources decode at the same addresses in single-chip and expanded modes.
// - Configuration bits can remove EPROM and EEPROM from the map.
// - After reset RAM decodes from address zero.
// - Remap register write moves RAM base to any 4-Kbyte boundary.
// - Register block is 64 bytes, decoded at 1000 hex after reset.
// - Remap register write moves register block to any 4-Kbyte boundary.
// - RAM and registers on one boundary hide the lowest 64 RAM bytes.
// - Priority is registers over RAM over ROM; only the winner is accessed.
// - Bootstrap ROM at BF00 to BFFF only after reset in bootstrap mode.
// - Single-chip and bootstrap modes enable ROM regardless of the ROM enable bit.
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH
`define MMD_REMAP_RESET 8'h01
`define MMD_REG_SIZE_BITS 6
`define MMD_RAM_SIZE_BITS 9
`define MMD_ROM_BASE 16'hD000
`define MMD_EE_BASE 16'hB600
`define MMD_EE_LAST 16'hB7FF
`define MMD_BOOT_BASE 16'hBF00
`define MMD_BOOT_LAST 16'hBFFF
`define MMD_MODE_SINGLE 2'h2
`define MMD_MODE_EXPAND 2'h3
`define MMD_MODE_BOOT 2'h0
`define MMD_MODE_TEST 2'h1
`define MMD_SYNC_FILL 2'h3
`endif

// [mmd_pkg.sv]
`default_nettype none
package mmd_pkg;
    typedef enum logic [4:0] {
        MMD_SEL_REG = 5'h01,
        MMD_SEL_RAM = 5'h02,
        MMD_SEL_ROM = 5'h04,
        MMD_SEL_EE = 5'h08,
        MMD_SEL_EXT = 5'h10
    } mmd_sel_t;
endpackage
`default_nettype wire

// [mmd_mode_latch.sv]
`include "mmd_defines.svh"
`default_nettype none
// ========================================
// Mode pin sampling and reset-time latch
module mmd_mode_latch (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic mode_b_pin,
    input wire logic mode_a_pin,
    output logic [1:0] mode_r,
    output logic mode_valid_r
);
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] fill_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            s3_r <= 2'h0;
        end else begin
            s1_r <= {mode_b_pin, mode_a_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Stages holding real pin samples since release
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fill_r <= 2'h0;
        end else if (fill_r != `MMD_SYNC_FILL) begin
            fill_r <= fill_r + 2'h1;
        end
    end

    // Capture once after release, when the filled synchroniser agrees
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= `MMD_MODE_SINGLE;
            mode_valid_r <= 1'b0;
        end else if (!mode_valid_r && fill_r == `MMD_SYNC_FILL && s2_r == s3_r) begin
            mode_r <= s3_r;
            mode_valid_r <= 1'b1;
        end
    end
endmodule // mmd_mode_latch
`default_nettype wire

// [mmd_decoder.sv]
`include "mmd_defines.svh"
`default_nettype none
// ========================================
// Memory map decoder
module mmd_decoder (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic mode_b_pin,
    input wire logic mode_a_pin,
    input wire logic rom_enable_bit,
    input wire logic ee_enable_bit,
    input wire logic remap_wr,
    input wire logic [7:0] remap_wdata,
    input wire logic [15:0] addr,
    input wire logic access_valid,
    output logic mode_ready,
    output logic [1:0] mode_out,
    output logic [7:0] remap_r,
    output logic [4:0] sel,
    output logic ext_access,
    output logic boot_rom_sel,
    output logic [15:0] local_addr
);
    logic [1:0] mode_r;
    logic mode_valid_r;
    logic expanded;
    logic boot_mode;
    logic rom_on;
    logic hit_reg;
    logic hit_ram;
    logic hit_rom;
    logic hit_ee;
    logic hit_boot;
    mmd_pkg::mmd_sel_t sel_c;

    function automatic logic in_block(input logic [15:0] a, input logic [3:0] base,
                                      input int unsigned bits);
        logic [15:0] mask;
        mask = 16'hFFFF << bits;
        in_block = (a[15:12] == base) && ((a[11:0] & mask[11:0]) == 12'h000);
    endfunction

    mmd_mode_latch u_mode (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .mode_b_pin(mode_b_pin),
        .mode_a_pin(mode_a_pin),
        .mode_r(mode_r),
        .mode_valid_r(mode_valid_r)
    );

    // ========================================
    // Remap register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            remap_r <= `MMD_REMAP_RESET;
        end else if (remap_wr) begin
            remap_r <= remap_wdata;
        end
    end

    // ========================================
    // Mode-derived enables
    assign expanded = mode_r[0];
    assign boot_mode = (mode_r == `MMD_MODE_BOOT);
    assign rom_on = expanded ? rom_enable_bit : 1'b1;

    // ========================================
    // Address hits
    always_comb begin
        hit_reg = in_block(addr, remap_r[3:0], `MMD_REG_SIZE_BITS);
        hit_ram = in_block(addr, remap_r[7:4], `MMD_RAM_SIZE_BITS);
        hit_rom = rom_on && (addr >= `MMD_ROM_BASE);
        hit_ee = ee_enable_bit && addr >= `MMD_EE_BASE && addr <= `MMD_EE_LAST;
        hit_boot = boot_mode && addr >= `MMD_BOOT_BASE && addr <= `MMD_BOOT_LAST;
    end

    // ========================================
    // Priority select
    always_comb begin
        if (hit_reg) begin
            sel_c = mmd_pkg::MMD_SEL_REG;
        end else if (hit_ram) begin
            sel_c = mmd_pkg::MMD_SEL_RAM;
        end else if (hit_rom || hit_boot) begin
            sel_c = mmd_pkg::MMD_SEL_ROM;
        end else if (hit_ee) begin
            sel_c = mmd_pkg::MMD_SEL_EE;
        end else if (expanded) begin
            sel_c = mmd_pkg::MMD_SEL_EXT;
        end else begin
            sel_c = mmd_pkg::mmd_sel_t'(5'h00);
        end
    end

    // ========================================
    // Registered outputs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel <= 5'h00;
            ext_access <= 1'b0;
            boot_rom_sel <= 1'b0;
            local_addr <= 16'h0000;
        end else begin
            sel <= (access_valid && mode_valid_r) ? sel_c : 5'h00;
            ext_access <= access_valid && mode_valid_r && sel_c == mmd_pkg::MMD_SEL_EXT;
            boot_rom_sel <= access_valid && mode_valid_r && !hit_reg && !hit_ram && hit_boot;
            local_addr <= addr;
        end
    end

    assign mode_ready = mode_valid_r;
    assign mode_out = mode_r;
endmodule // mmd_decoder
`default_nettype wire

// [mmd_cpu_model.sv]
`default_nettype none
module mmd_cpu_model (
    input wire logic core_clk,
    input wire logic [15:0] req,
    input wire logic req_v,
    output logic [15:0] addr = 16'h0000,
    output logic access_valid = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(negedge core_clk) access_valid <= req_v;
    always @(negedge core_clk) addr <= req_v ? req : ~addr;
endmodule // mmd_cpu_model
`default_nettype wire

// [mmd_decoder_sva.sv]
`default_nettype none
module mmd_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [15:0] addr,
    input wire logic access_valid,
    input wire logic mode_ready,
    input wire logic [1:0] mode_out,
    input wire logic [7:0] remap_r,
    input wire logic [4:0] sel,
    input wire logic ext_access,
    input wire logic boot_rom_sel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sel_onehot_a: assert property ($onehot0(sel)) else $error("sel");
    idle_none_a: assert property (!mode_ready |=> sel == 5'h00) else $error("idle");
    mode_hold_a: assert property (mode_ready |=> $stable(mode_out)) else $error("mode");
    ready_hold_a: assert property (mode_ready |=> mode_ready) else $error("rdy");
    ext_mode_a: assert property (ext_access |-> mode_out[0]) else $error("ext");
    ext_sel_a: assert property (ext_access |-> sel == 5'h10) else $error("ext");
    boot_mode_a: assert property (boot_rom_sel |-> mode_out == 2'h0) else $error("boot");
    reg_win_a: assert property (access_valid && mode_ready
        && addr[15:6] == {remap_r[3:0], 6'h00} |=> sel == 5'h01) else $error("reg");
    ram_win_a: assert property (access_valid && mode_ready
        && addr[15:9] == {remap_r[7:4], 3'h0}
        && addr[15:6] != {remap_r[3:0], 6'h00} |=> sel == 5'h02) else $error("ram");
    no_req_a: assert property (!access_valid |=> sel == 5'h00) else $error("no request");
endmodule // mmd_chk
bind mmd_decoder mmd_chk u_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .addr(addr),
    .access_valid(access_valid),
    .mode_ready(mode_ready),
    .mode_out(mode_out),
    .remap_r(remap_r),
    .sel(sel),
    .ext_access(ext_access),
    .boot_rom_sel(boot_rom_sel)
);
`default_nettype wire

// [memory_map_decoder_tb_top.sv]
`default_nettype none
// ====
// Decoder bench
module memory_map_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'h0, rst_b = 1'h0, remap_wr = 1'h0, req_v = 1'h0, access_valid, r;
    logic mb, ma, ro, ee, ext_access, boot_rom_sel;
    logic [1:0] mode_out;
    logic [4:0] sel;
    logic [7:0] remap_wdata = 8'h33, rm, remap_r;
    logic [15:0] req = 16'h0000, addr, local_addr;
    logic [15:0] pts [7] = '{16'h1000, 16'h0040, 16'h3000, 16'h3040, 16'hBF00, 16'hB600, 16'hE000};
    int failures = 0, compares = 0, seed = 32'h67e0;
    always #20 core_clk = ~core_clk;
    mmd_cpu_model cpu (.core_clk(core_clk), .req(req), .req_v(req_v), .addr(addr),
        .access_valid(access_valid));
    mmd_decoder DUT (.core_clk(core_clk), .rst_b(rst_b), .mode_b_pin(mb), .mode_a_pin(ma),
        .rom_enable_bit(ro), .ee_enable_bit(ee), .remap_wr(remap_wr),
        .remap_wdata(remap_wdata), .addr(addr), .access_valid(access_valid),
        .mode_ready(r), .mode_out(mode_out), .remap_r(remap_r), .sel(sel),
        .ext_access(ext_access), .boot_rom_sel(boot_rom_sel), .local_addr(local_addr));
    function automatic logic [4:0] want(input logic [15:0] a);
        if (a[15:6] == {rm[3:0], 6'h00}) return 5'h01;
        if (a[15:9] == {rm[7:4], 3'h0}) return 5'h02;
        if (a >= 16'hD000 && (ro || !ma) || a[15:8] == 8'hBF && !mb && !ma) return 5'h04;
        if (a[15:9] == 7'h5B && ee) return 5'h08;
        return ma ? 5'h10 : 5'h00;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        failures += int'(g !== e);
        if (g !== e) $display("mismatch %s expected %h seen %h", n, e, g);
    endtask
    task automatic chk_addr(input string n, input logic [15:0] e, g);
        compares++;
        failures += int'(g !== e);
        if (g !== e) $display("mismatch %s expected %h seen %h", n, e, g);
    endtask
    task automatic acc(input logic [15:0] a);
        logic [4:0] w;
        w = want(a);
        @(posedge core_clk) {req, req_v} <= {a, 1'h1};
        @(posedge core_clk) req_v <= 1'h0;
        @(negedge core_clk) chk("sel", {3'h0, w}, {3'h0, sel});
        chk("ext", {7'h00, w == 5'h10}, {7'h00, ext_access});
        chk("boot", {7'h00, w == 5'h04 && a[15:8] == 8'hBF}, {7'h00, boot_rom_sel});
        chk_addr("local_addr", a, local_addr);
    endtask
    task automatic end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 4; i++) begin
            {mb, ma, rm, rst_b, ro, ee} = {i[1:0], 8'h01, 1'h0, 2'($random(seed))};
            remap_wdata = 8'h33;
            repeat (4) @(negedge core_clk);
            rst_b = 1'h1;
            for (int t = 0; t < 20 && r !== 1'h1; t++) @(negedge core_clk);
            chk("mode", {5'h00, 1'h1, mb, ma}, {5'h00, r, mode_out});
            if (r !== 1'h1) break;
            repeat (2) begin
                foreach (pts[k]) acc(pts[k]);
                remap_wr = 1'h1;
                @(negedge core_clk) {remap_wr, rm} = {1'h0, remap_wdata};
                chk("remap", rm, remap_r);
                remap_wdata = 8'($random(seed));
            end
            repeat (4) acc({rm[7:4], 3'h0, 9'($random(seed))});
            repeat (10) acc(16'($random(seed)));
            $display("mode %0d done", i);
        end
        end_sim;
    end
endmodule // memory_map_decoder_tb_top
`default_nettype wire
